// [src/cam_pkg.sv]
// Purpose: shared constants and types of the clock accuracy monitor
// Assumes: APB register access, 32-bit data, one word per register
// Notes: offsets are byte addresses on the APB bus
package cam_pkg;
   // -------------------------------------------------------------
   // register offsets
   // -------------------------------------------------------------
   localparam logic [7:0] CAM_OFF_CTRL1 = 8'h00;   // measure_control_1
   localparam logic [7:0] CAM_OFF_CTRL2 = 8'h04;   // measure_control_2
   localparam logic [7:0] CAM_OFF_STOP = 8'h08;    // module stop control
   localparam logic [7:0] CAM_OFF_UPPER = 8'h0C;   // upper count limit
   localparam logic [7:0] CAM_OFF_LOWER = 8'h10;   // lower count limit
   localparam logic [7:0] CAM_OFF_COUNT = 8'h14;   // captured count, read only
   localparam logic [7:0] CAM_OFF_STATUS = 8'h18;  // sticky events, write one to clear
   localparam logic [7:0] CAM_OFF_MASK = 8'h1C;    // interrupt mask

   // -------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------
   localparam int CAM_EN_BIT = 0;        // ctrl1: measurement enable
   localparam int CAM_EXT_BIT = 0;       // ctrl2: use external reference pin
   localparam int CAM_SEL_LSB = 1;       // selector field low bit
   localparam int CAM_SEL_MSB = 3;       // selector field high bit
   localparam int CAM_ST_END = 0;        // status: measurement end
   localparam int CAM_ST_FERR = 1;       // status: frequency error
   localparam int CAM_ST_OVF = 2;        // status: counter overflow
   localparam int CAM_ST_BUSY = 7;       // status: interval running, read only
   localparam int CAM_NEVT = 3;          // number of event bits

   // -------------------------------------------------------------
   // clock source codes
   // -------------------------------------------------------------
   localparam logic [2:0] CAM_CLK_MAIN = 3'h0;   // main oscillator
   localparam logic [2:0] CAM_CLK_SUB = 3'h1;    // sub-oscillator
   localparam logic [2:0] CAM_CLK_FAST = 3'h2;   // fast internal oscillator
   localparam logic [2:0] CAM_CLK_SLOW = 3'h3;   // slow internal oscillator
   localparam logic [2:0] CAM_CLK_WDT = 3'h4;    // watchdog oscillator clock
   localparam logic [2:0] CAM_CLK_PERIPHERAL_CLOCK_B = 3'h5;  // peripheral clock b
   localparam int CAM_NSRC = 7;                  // six clocks plus the pin
   localparam int CAM_EXT_IDX = 6;               // position of the pin

   // -------------------------------------------------------------
   // reset values
   // -------------------------------------------------------------
   localparam logic [7:0] CAM_CTRL_RST = 8'h00;
   localparam logic CAM_STOP_RST = 1'b1;
   localparam logic [15:0] CAM_UPPER_RST = 16'hFFFF;
   localparam logic [15:0] CAM_LOWER_RST = 16'h0000;
   localparam logic [2:0] CAM_MASK_RST = 3'h0;

   // measurement sequencer
   typedef enum logic [1:0] {CAM_IDLE, CAM_ARM, CAM_MEAS} cam_state_t;
endpackage

// [src/cam_sync.sv]
// Purpose: two-flop synchronisers for the monitored clock inputs
// Assumes: inputs are slow against pclk or merely sampled
// Notes: one generate loop, one lane per input
`timescale 1ns/1ps
module cam_sync #(
   parameter int N = 7              // number of lanes
) (
   input wire logic pclk,           // bus clock
   input wire logic presetn,        // async reset, active low
   input wire logic [N-1:0] din,    // raw levels
   output logic [N-1:0] dout        // synchronised levels
);
   // -------------------------------------------------------------
   // synchroniser lanes
   // -------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_lane
         logic meta_q;   // first stage, read only by the second
         logic meta_d;
         logic sync_q;
         logic sync_d;
         // next values
         always_comb begin
            meta_d = din[i];
            sync_d = meta_q;
         end
         // registers
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               meta_q <= 1'b0;
               sync_q <= 1'b0;
            end else begin
               meta_q <= meta_d;
               sync_q <= sync_d;
            end
         end
         assign dout[i] = sync_q;
      end
   endgenerate
endmodule

// [src/cam_edge_pick.sv]
// Purpose: pick one synchronised clock by code and flag its rising edges
// Assumes: illegal codes never written by software; they yield no edges
// Notes: legacy build removes main oscillator and peripheral clock b
`timescale 1ns/1ps
module cam_edge_pick import cam_pkg::*; #(
   parameter bit LEGACY = 1'b0            // earliest silicon subset
) (
   input wire logic pclk,                 // bus clock
   input wire logic presetn,              // async reset, active low
   input wire logic [CAM_NSRC-1:0] src,   // synchronised sources
   input wire logic [2:0] sel,            // clock select code
   input wire logic use_ext,              // take the external pin instead
   output logic edge_q                    // one-cycle pulse per rising edge
);
   logic lvl_q;    // previous picked level
   logic lvl_d;
   logic edge_d;
   logic valid;    // selected code exists on this build

   // -------------------------------------------------------------
   // source pick and edge detect
   // -------------------------------------------------------------
   always_comb begin
      valid = (sel <= CAM_CLK_PERIPHERAL_CLOCK_B);
      if (LEGACY && (sel == CAM_CLK_MAIN || sel == CAM_CLK_PERIPHERAL_CLOCK_B)) begin
         valid = 1'b0;
      end
      if (use_ext) begin
         lvl_d = src[CAM_EXT_IDX];
      end else if (valid) begin
         lvl_d = src[sel];
      end else begin
         lvl_d = 1'b0;  // unsupported code: no edges rather than garbage
      end
      edge_d = lvl_d & ~lvl_q;
   end

   // registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lvl_q <= 1'b0;
         edge_q <= 1'b0;
      end else begin
         lvl_q <= lvl_d;
         edge_q <= edge_d;
      end
   end

   chk_legacy_block: assert property (@(posedge pclk) disable iff (!presetn)
      (LEGACY && !use_ext && (sel == CAM_CLK_MAIN || sel == CAM_CLK_PERIPHERAL_CLOCK_B)) |=> !edge_q)
      else $error("legacy build produced an edge for a removed source");
   chk_ext_edge: assert property (@(posedge pclk) disable iff (!presetn)
      (use_ext && src[CAM_EXT_IDX] && !lvl_q) |=> edge_q)
      else $error("external reference edge not flagged");
endmodule

// [src/cam_top.sv]
// Purpose: clock accuracy monitor with APB registers and one interrupt
// Assumes: all clock inputs are sampled in the pclk domain
// Notes: measured clocks must run below half of pclk to be counted
//
// Summary of operation
// - measured select bits 3:1, six clock codes
// - reference select bits 3:1, same six codes
// - external reference pin usable as reference
// - end, frequency error, overflow events raised
// - module stop halts the block
// - legacy build: only codes 001 to 100
`timescale 1ns/1ps
module cam_top import cam_pkg::*; #(
   parameter int CNT_W = 16,                  // counter width
   parameter bit LEGACY = 1'b0                // earliest silicon subset
) (
   input wire logic pclk,                     // bus clock
   input wire logic presetn,                  // async reset, active low
   input wire logic [7:0] paddr,              // apb address
   input wire logic psel,                     // apb select
   input wire logic penable,                  // apb access phase
   input wire logic pwrite,                   // apb direction
   input wire logic [31:0] pwdata,            // apb write data
   output logic [31:0] prdata,                // apb read data
   output logic pready,                       // apb ready
   output logic pslverr,                      // apb error
   input wire logic main_oscillator,          // main oscillator clock
   input wire logic sub_oscillator,           // sub-oscillator clock
   input wire logic fast_internal_oscillator, // fast on-chip oscillator
   input wire logic slow_internal_oscillator, // slow on-chip oscillator
   input wire logic watchdog_oscillator_clock,// watchdog oscillator
   input wire logic peripheral_clock_b,       // peripheral clock b
   input wire logic external_reference_input, // reference pin
   output logic irq                           // level interrupt
);
   // -------------------------------------------------------------
   // declarations
   // -------------------------------------------------------------
   logic [CAM_NSRC-1:0] raw_src;   // raw clock levels
   logic [CAM_NSRC-1:0] sync_src;  // synchronised levels
   logic meas_edge;                // measured clock rising edge
   logic ref_edge;                 // reference rising edge
   logic en_q, en_d;               // measurement enable
   logic [2:0] meas_sel_q, meas_sel_d;  // measured_clock_select
   logic [2:0] ref_sel_q, ref_sel_d;    // reference_clock_select
   logic ext_q, ext_d;             // reference from pin
   logic stop_q, stop_d;           // module stop
   logic [CNT_W-1:0] upper_q, upper_d;  // upper limit
   logic [CNT_W-1:0] lower_q, lower_d;  // lower limit
   logic [CNT_W-1:0] cap_q, cap_d;      // count of last interval
   logic [CAM_NEVT-1:0] status_q, status_d;  // sticky events
   logic [CAM_NEVT-1:0] mask_q, mask_d;      // interrupt mask
   logic [CAM_NEVT-1:0] evt;       // events of this cycle
   logic [CNT_W-1:0] count_q, count_d;  // running edge count
   cam_state_t state_q, state_d;   // sequencer
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;
   logic irq_q, irq_d;
   logic setup;                    // apb setup cycle
   logic wr_done;                  // write completes at this edge
   logic hit;                      // address decodes to a register
   logic [31:0] rd_word;           // read mux

   assign raw_src = {external_reference_input, peripheral_clock_b,
      watchdog_oscillator_clock, slow_internal_oscillator,
      fast_internal_oscillator, sub_oscillator, main_oscillator};

   // -------------------------------------------------------------
   // clock input path
   // -------------------------------------------------------------
   cam_sync #(.N(CAM_NSRC)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .din(raw_src),
      .dout(sync_src)
   );

   // the measured side never looks at the pin
   cam_edge_pick #(.LEGACY(LEGACY)) u_meas (
      .pclk(pclk),
      .presetn(presetn),
      .src(sync_src),
      .sel(meas_sel_q),
      .use_ext(1'b0),
      .edge_q(meas_edge)
   );

   cam_edge_pick #(.LEGACY(LEGACY)) u_ref (
      .pclk(pclk),
      .presetn(presetn),
      .src(sync_src),
      .sel(ref_sel_q),
      .use_ext(ext_q),
      .edge_q(ref_edge)
   );

   // -------------------------------------------------------------
   // apb decode and register writes
   // -------------------------------------------------------------
   // a refused address still answers in the access cycle, so a bad
   // offset never stalls the bus; pslverr tells software it missed
   always_comb begin
      setup = psel && !penable;
      wr_done = psel && penable && pready_q && pwrite && !pslverr_q;
      hit = (paddr[1:0] == 2'h0) && (paddr <= CAM_OFF_MASK);
      pready_d = setup;   // no wait state, ready always from a flop
      pslverr_d = setup ? !hit : 1'b0;
      en_d = en_q;
      meas_sel_d = meas_sel_q;
      ref_sel_d = ref_sel_q;
      ext_d = ext_q;
      stop_d = stop_q;
      upper_d = upper_q;
      lower_d = lower_q;
      mask_d = mask_q;
      if (wr_done) begin
         unique case (paddr)
            CAM_OFF_CTRL1: begin
               en_d = pwdata[CAM_EN_BIT];
               meas_sel_d = pwdata[CAM_SEL_MSB:CAM_SEL_LSB];
            end
            CAM_OFF_CTRL2: begin
               ext_d = pwdata[CAM_EXT_BIT];
               ref_sel_d = pwdata[CAM_SEL_MSB:CAM_SEL_LSB];
            end
            CAM_OFF_STOP: stop_d = pwdata[0];
            CAM_OFF_UPPER: upper_d = pwdata[CNT_W-1:0];
            CAM_OFF_LOWER: lower_d = pwdata[CNT_W-1:0];
            CAM_OFF_MASK: mask_d = pwdata[CAM_NEVT-1:0];
            default: ;    // count and status need no stored write here
         endcase
      end
   end

   // -------------------------------------------------------------
   // read mux, captured in the setup cycle
   // -------------------------------------------------------------
   // capturing at setup keeps prdata straight from a flop, at the cost
   // of showing the value one cycle older than the access edge
   always_comb begin
      rd_word = 32'h0000_0000;
      unique case (paddr)
         CAM_OFF_CTRL1: rd_word[3:0] = {meas_sel_q, en_q};
         CAM_OFF_CTRL2: rd_word[3:0] = {ref_sel_q, ext_q};
         CAM_OFF_STOP: rd_word[0] = stop_q;
         CAM_OFF_UPPER: rd_word[CNT_W-1:0] = upper_q;
         CAM_OFF_LOWER: rd_word[CNT_W-1:0] = lower_q;
         CAM_OFF_COUNT: rd_word[CNT_W-1:0] = cap_q;
         CAM_OFF_STATUS: begin
            rd_word[CAM_NEVT-1:0] = status_q;
            rd_word[CAM_ST_BUSY] = (state_q == CAM_MEAS);
         end
         CAM_OFF_MASK: rd_word[CAM_NEVT-1:0] = mask_q;
         default: rd_word = 32'h0000_0000;  // unmapped: mux gives zero, but prdata is not captured and keeps its last value
      endcase
      prdata_d = (setup && !pwrite && hit) ? rd_word : prdata_q;
   end

   // -------------------------------------------------------------
   // measurement sequencer
   // -------------------------------------------------------------
   // a new interval starts on every reference edge; a measured edge in
   // the same cycle is counted into the new interval, not the old one
   // overflow only flags the wrap; the interval keeps counting on
   always_comb begin
      state_d = state_q;
      count_d = count_q;
      cap_d = cap_q;
      evt = '0;
      if (stop_q || !en_q) begin
         state_d = CAM_IDLE;
         count_d = '0;
      end else begin
         unique case (state_q)
            CAM_IDLE: state_d = CAM_ARM;
            CAM_ARM: begin
               if (ref_edge) begin
                  state_d = CAM_MEAS;
                  count_d = meas_edge ? CNT_W'(1) : '0;
               end
            end
            CAM_MEAS: begin
               if (ref_edge) begin
                  cap_d = count_q;
                  evt[CAM_ST_END] = 1'b1;
                  evt[CAM_ST_FERR] = (count_q > upper_q) || (count_q < lower_q);
                  count_d = meas_edge ? CNT_W'(1) : '0;
               end else if (meas_edge) begin
                  evt[CAM_ST_OVF] = &count_q;
                  count_d = count_q + CNT_W'(1);  // wraps to zero
               end
            end
         endcase
      end
   end

   // -------------------------------------------------------------
   // sticky status and interrupt
   // -------------------------------------------------------------
   // an event in the clearing cycle survives: set wins over clear
   always_comb begin
      status_d = status_q;
      if (wr_done && paddr == CAM_OFF_STATUS) begin
         status_d = status_q & ~pwdata[CAM_NEVT-1:0];
      end
      status_d = status_d | evt;
      irq_d = |(status_d & mask_d);
   end

   // -------------------------------------------------------------
   // registers
   // -------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_q <= CAM_CTRL_RST[CAM_EN_BIT];
         meas_sel_q <= CAM_CTRL_RST[CAM_SEL_MSB:CAM_SEL_LSB];
         ref_sel_q <= CAM_CTRL_RST[CAM_SEL_MSB:CAM_SEL_LSB];
         ext_q <= CAM_CTRL_RST[CAM_EXT_BIT];
         stop_q <= CAM_STOP_RST;
         upper_q <= CAM_UPPER_RST[CNT_W-1:0];
         lower_q <= CAM_LOWER_RST[CNT_W-1:0];
         cap_q <= '0;
         status_q <= '0;
         mask_q <= CAM_MASK_RST;
         count_q <= '0;
         state_q <= CAM_IDLE;
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         en_q <= en_d;
         meas_sel_q <= meas_sel_d;
         ref_sel_q <= ref_sel_d;
         ext_q <= ext_d;
         stop_q <= stop_d;
         upper_q <= upper_d;
         lower_q <= lower_d;
         cap_q <= cap_d;
         status_q <= status_d;
         mask_q <= mask_d;
         count_q <= count_d;
         state_q <= state_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         irq_q <= irq_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign irq = irq_q;

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_meas_sel_write: assert property (
      (wr_done && paddr == CAM_OFF_CTRL1) |=> meas_sel_q == $past(pwdata[3:1]))
      else $error("measured selector not updated by write");
   chk_ref_sel_write: assert property (
      (wr_done && paddr == CAM_OFF_CTRL2) |=> ref_sel_q == $past(pwdata[3:1]))
      else $error("reference selector not updated by write");
   chk_ext_select: assert property (
      (wr_done && paddr == CAM_OFF_CTRL2) |=> ext_q == $past(pwdata[0]))
      else $error("external reference choice not stored");
   chk_end_event: assert property (
      (state_q == CAM_MEAS && ref_edge && en_q && !stop_q)
      |=> status_q[CAM_ST_END] && cap_q == $past(count_q))
      else $error("interval end not flagged or count not captured");
   chk_ferr_limit: assert property (
      (state_q == CAM_MEAS && ref_edge && en_q && !stop_q && count_q > upper_q)
      |=> status_q[CAM_ST_FERR])
      else $error("count above upper limit not flagged");
   chk_ovf_wrap: assert property (
      (state_q == CAM_MEAS && meas_edge && !ref_edge && en_q && !stop_q && &count_q)
      |=> status_q[CAM_ST_OVF] && count_q == '0)
      else $error("counter wrap not flagged");
   chk_stop_hold: assert property (
      stop_q ##1 stop_q |-> state_q == CAM_IDLE && count_q == '0 && $stable(cap_q))
      else $error("block active during module stop");
   chk_irq_level: assert property (
      irq_q == |(status_q & mask_q))
      else $error("interrupt does not follow masked status");

   // a count equal to either limit is in range; only strictly outside flags
   chk_ferr_low: assert property (
      (state_q == CAM_MEAS && ref_edge && en_q && !stop_q && count_q < lower_q)
      |=> status_q[CAM_ST_FERR])
      else $error("count below lower limit not flagged");
   // the captured count moves only at the end of an interval
   chk_cap_hold: assert property (
      !(state_q == CAM_MEAS && ref_edge && en_q && !stop_q) |=> $stable(cap_q))
      else $error("captured count changed inside an interval");
   // an event in the clearing cycle must survive the clear
   chk_set_wins: assert property (
      (|evt) |=> (status_q & $past(evt)) == $past(evt))
      else $error("event lost against a same-cycle clear");
   // ready stands for exactly the access cycle after each setup
   chk_ready_pulse: assert property (
      setup |=> pready_q ##1 !pready_q)
      else $error("ready not a single cycle after setup");
   // leaving module stop with enable set arms the sequencer at once
   chk_idle_arm: assert property (
      (state_q == CAM_IDLE && en_q && !stop_q) |=> state_q == CAM_ARM)
      else $error("sequencer did not arm after enable");
endmodule

// [dv/cam_osc_model.sv]
// Purpose: behavioural oscillators and reference pin seen by the monitor
// Assumes: half periods are multiples of 50 ns, so edges avoid pclk rising edges
// Notes: a stopped source holds low, as a gated oscillator would
`timescale 1ns/1ps
module cam_osc_model (
   input wire logic [6:0] run, // per-source run enables
   output logic [6:0] osc      // six clock sources, then the reference pin
);
   // ------------------------------------------------------------
   // oscillators
   // ------------------------------------------------------------
   // half periods in ns, all distinct so a wrong select shows in the count
   localparam int HALF [0:6] = '{150, 2000, 250, 3000, 350, 4000, 12000};
   for (genvar gi = 0; gi < 7; gi++) begin : g_osc
      // one toggling source; index 6 is the reference pin
      initial begin
         osc[gi] = 1'b0;
         forever begin
            #(HALF[gi]);
            osc[gi] = run[gi] ? ~osc[gi] : 1'b0;
         end
      end
   end
endmodule

// [dv/clock_accuracy_monitor_bench.sv]
// Purpose: self-checking bench for the clock accuracy monitor
// Assumes: source periods known from the oscillator model
// Notes: counter narrowed to 8 bits so an overflow shows quickly
`timescale 1ns/1ps
module clock_accuracy_monitor_bench import cam_pkg::*;;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   localparam int CW = 8;        // narrowed counter width
   localparam int EXT_P = 24000; // reference pin period in ns
   localparam int PER [0:5] = '{300, 4000, 500, 6000, 700, 8000}; // source periods
   localparam logic [31:0] RST [0:7] = '{32'h0, 32'h0, 32'h1, 32'hFF, 32'h0, 32'h0,
      32'h0, 32'h0};             // reset value per offset
   logic pclk = 1'b0;            // bus clock
   logic presetn = 1'b0;         // reset, active low
   logic [7:0] paddr = 8'h00;    // apb address
   logic psel = 1'b0;            // apb select
   logic penable = 1'b0;         // apb access phase
   logic pwrite = 1'b0;          // apb direction
   logic [31:0] pwdata = 32'h0;  // apb write data
   logic [31:0] prdata;          // apb read data
   logic pready;                 // apb ready
   logic pslverr;                // apb error
   logic irq;                    // interrupt
   logic [6:0] run = 7'h7F;      // oscillator run enables
   logic [6:0] osc;              // oscillator outputs
   logic [31:0] rv;              // last read value
   logic ev;                     // last error flag
   logic [31:0] st;              // status seen at the end event
   logic [31:0] prdata_l;        // legacy build read data
   logic [31:0] rl;              // legacy build last read value
   int num_errors = 0;
   int n_compared = 0;

   // 20 MHz bus clock
   always #25 pclk = ~pclk;

   cam_osc_model osc_u (.run(run), .osc(osc));
   cam_top #(.CNT_W(CW)) dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .main_oscillator(osc[0]),
      .sub_oscillator(osc[1]), .fast_internal_oscillator(osc[2]),
      .slow_internal_oscillator(osc[3]), .watchdog_oscillator_clock(osc[4]),
      .peripheral_clock_b(osc[5]), .external_reference_input(osc[6]), .irq(irq));
   // legacy build on the same bus: removed sources must give no edges
   cam_top #(.CNT_W(CW), .LEGACY(1'b1)) leg_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata_l),
      .pready(), .pslverr(), .main_oscillator(osc[0]), .sub_oscillator(osc[1]),
      .fast_internal_oscillator(osc[2]), .slow_internal_oscillator(osc[3]),
      .watchdog_oscillator_clock(osc[4]), .peripheral_clock_b(osc[5]),
      .external_reference_input(osc[6]), .irq());

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   // compare and count
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   // edge counts may be off by one at interval boundaries
   task automatic chk_cnt(input int e);
      n_compared++;
      if ((rv >= e - 1 && rv <= e + 1) !== 1'b1) begin
         num_errors++;
         $display("ERROR count expected %0d seen %0d", e, rv);
      end
   endtask

   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rv = prdata;
      rl = prdata_l;
      ev = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 16) chk("pready", 32'h1, 32'h0);
   endtask

   // reprogram while disabled, enable, wait for an end event, fetch the count
   task automatic meas(input logic [2:0] m, input logic ext, input logic [2:0] r);
      int n;
      n = 0;
      apb(1'b1, CAM_OFF_CTRL1, 32'h0);
      apb(1'b1, CAM_OFF_STATUS, 32'h7);
      apb(1'b1, CAM_OFF_CTRL2, {28'h0, r, ext});
      apb(1'b1, CAM_OFF_CTRL1, {28'h0, m, 1'b1});
      do begin
         apb(1'b0, CAM_OFF_STATUS, 32'h0);
         n++;
      end while (rv[CAM_ST_END] !== 1'b1 && n < 1000);
      if (rv[CAM_ST_END] !== 1'b1) chk("end event", 32'h1, 32'h0);
      st = rv;
      apb(1'b0, CAM_OFF_COUNT, 32'h0);
   endtask

   // verdict and end of run
   task automatic print_verdict();
      if (num_errors == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      // reset values of every register
      for (int i = 0; i < 8; i++) begin
         apb(1'b0, 8'(4 * i), 32'h0);
         chk("reset value", RST[i], rv);
      end
      // unmapped and misaligned places are refused
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, ev});
      apb(1'b0, 8'h02, 32'h0);
      chk("misaligned error", 32'h1, {31'h0, ev});
      apb(1'b1, CAM_OFF_CTRL2, 32'hB);
      apb(1'b0, CAM_OFF_CTRL2, 32'h0);
      chk("ctrl2 readback", 32'hB, rv);
      apb(1'b1, CAM_OFF_STOP, 32'h0);
      // every measured code against the reference pin
      for (int m = 0; m < 6; m++) begin
         meas(3'(m), 1'b1, 3'h0);
         chk_cnt(EXT_P / PER[m]);
         chk("events", 32'h1, {29'h0, st[2:0]});
         if (m == 0 || m == 5) chk("legacy count", 32'h0, rl);
      end
      // every reference code, measuring the fastest source
      for (int r = 0; r < 6; r++) begin
         meas(3'h0, 1'b0, 3'(r));
         chk_cnt(PER[r] / PER[0]);
      end
      // count above the upper limit, then below the lower limit
      apb(1'b1, CAM_OFF_UPPER, 32'h20);
      meas(3'h0, 1'b1, 3'h0);
      chk("high error", 32'h3, {29'h0, st[2:0]});
      chk("irq masked", 32'h0, {31'h0, irq});
      apb(1'b1, CAM_OFF_UPPER, 32'hFF);
      apb(1'b1, CAM_OFF_LOWER, 32'h60);
      meas(3'h0, 1'b1, 3'h0);
      chk("low error", 32'h3, {29'h0, st[2:0]});
      apb(1'b1, CAM_OFF_LOWER, 32'h0);
      // unmasked error raises the line, clearing drops it
      apb(1'b1, CAM_OFF_MASK, 32'h2);
      repeat (2) @(posedge pclk);
      chk("irq raised", 32'h1, {31'h0, irq});
      apb(1'b1, CAM_OFF_CTRL1, 32'h0);
      apb(1'b1, CAM_OFF_STATUS, 32'h2);
      repeat (2) @(posedge pclk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      // stall the reference mid-interval so the counter wraps
      meas(3'h0, 1'b1, 3'h0);
      run[6] <= 1'b0;
      apb(1'b1, CAM_OFF_STATUS, 32'h7);
      repeat (2000) @(posedge pclk);
      apb(1'b0, CAM_OFF_STATUS, 32'h0);
      chk("overflow", 32'h4, {29'h0, rv[2:0]});
      // module stop halts all activity while still enabled
      apb(1'b1, CAM_OFF_STOP, 32'h1);
      run[6] <= 1'b1;
      apb(1'b1, CAM_OFF_STATUS, 32'h7);
      repeat (1500) @(posedge pclk);
      apb(1'b0, CAM_OFF_STATUS, 32'h0);
      chk("stopped", 32'h0, rv);
      print_verdict();
   end

   // watchdog against a hung handshake or sequencer
   initial begin
      repeat (60000) @(posedge pclk);
      num_errors++;
      print_verdict();
   end
endmodule
